// [dv/ecf_csr_props.sv]
/* Port checker for the feature control register block.
   Assumes one clock and an async high reset; bound below. */
`timescale 1ns/1ps
module ecf_csr_props (
   input wire clk,
   input wire rst,
   input wire [11:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   input wire integ_auto,
   input wire gain_auto,
   input wire [11:0] integ_setting,
   input wire [31:0] rdata,
   input wire expo_active,
   input wire integ_up,
   input wire integ_down,
   input wire gain_up,
   input wire gain_down,
   input wire [11:0] red_gain,
   input wire [11:0] green_gain
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Read answer stands in the cycle after the strobe
   sequence read_at(logic [11:0] a);
      rd && addr == a ##1 1'b1;
   endsequence
   sequence auto_wr;
      wr && addr == 12'h804 && wdata[25:24] == 2'b11;
   endsequence
   edge_absent_a: assert property (read_at(12'h808) |-> rdata == 32'h0)
      else $error("edge enhance word not zero");
   expo_layout_a: assert property (read_at(12'h804) |-> rdata[31]
      && rdata[29:27] == 3'h0 && rdata[23:12] == 12'h0)
      else $error("exposure presence or reserved bits wrong");
   integ_owner_a: assert property (integ_up || integ_down |-> integ_auto)
      else $error("integration moved while not in auto");
   gain_owner_a: assert property (gain_up || gain_down |-> gain_auto)
      else $error("gain moved while not in auto");
   integ_first_a: assert property (gain_up |->
      !integ_auto || integ_setting == 12'hfff)
      else $error("gain raised before integration");
   // Gives pipelined outputs room for one extra register stage
   enable_off_a: assert property (wr && addr == 12'h804 && !wdata[25]
      |-> ##3 !expo_active [*3])
      else $error("exposure control still active when off");
   color_off_a: assert property (wr && addr == 12'h80c && !wdata[25]
      |-> ##3 red_gain == green_gain)
      else $error("colour gain off but red gain differs");
   auto_readback_a: assert property (auto_wr ##2 auto_wr
      ##2 read_at(12'h804) |-> rdata[24])
      else $error("auto select bit not read back");
   green_default_a: assert property (!$past(rst) |-> green_gain == 12'h016)
      else $error("green gain not default");
endmodule

bind ecf_csr ecf_csr_props props (.clk(clk), .rst(rst), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .integ_auto(integ_auto),
   .gain_auto(gain_auto), .integ_setting(integ_setting), .rdata(rdata),
   .expo_active(expo_active), .integ_up(integ_up), .integ_down(integ_down),
   .gain_up(gain_up), .gain_down(gain_down), .red_gain(red_gain),
   .green_gain(green_gain));

// [dv/ecf_host.sv]
/* Host software model: one-cycle register writes and reads.
   Assumes callers enter its tasks after a rising clock edge. */
`timescale 1ns/1ps
module ecf_host (
   input wire clk,
   input wire [31:0] rdata,
   output reg [11:0] addr,
   output reg [31:0] wdata,
   output reg wr,
   output reg rd
);
   initial begin
      addr = 12'h0;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
   end
   // Value fields are written only in manual unless a test means otherwise
   task put(input [11:0] a, input [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      wdata <= ~d; // Stale data must not look valid
   endtask
   // Answer is taken in the one cycle it stands
   task get(input [11:0] a, output [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
endmodule

// [dv/testbench.sv]
/* Self-checking bench for the feature control registers.
   Assumes ecf_csr, the host model and the bound checker. */
`timescale 1ns/1ps
module testbench;
   reg clk, rst, integ_auto, gain_auto, pixel_frame, saw_i, saw_g;
   reg [11:0] integ_setting, avg_intensity, gain_setting, abs_exposure;
   reg [31:0] d;
   wire [11:0] addr, red_gain, blue_gain, green_gain;
   wire [31:0] wdata, rdata;
   wire wr, rd, expo_active, integ_up, integ_down, gain_up, gain_down;
   integer errors = 0;
   integer samples_checked = 0;
   // Absolute colour gains tied to the mid code; absolute exposure mode is driven through abs_exposure
   ecf_csr #(.COLOR(1), .ONESHOT_CYC(8)) dut (.clk(clk), .rst(rst),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .integ_auto(integ_auto),
      .gain_auto(gain_auto), .integ_setting(integ_setting),
      .gain_setting(gain_setting), .avg_intensity(avg_intensity),
      .abs_exposure(abs_exposure), .abs_red(12'h800), .abs_blue(12'h800),
      .pixel_frame(pixel_frame), .rdata(rdata), .expo_active(expo_active),
      .integ_up(integ_up), .integ_down(integ_down), .gain_up(gain_up),
      .gain_down(gain_down), .red_gain(red_gain), .blue_gain(blue_gain),
      .green_gain(green_gain));
   ecf_host host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task check(input string name, input [31:0] seen, input [31:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
         errors = errors + 1;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task rchk(input [11:0] a, input [31:0] exp);
      host.get(a, d);
      check("word", d, exp);
   endtask
   // One frame pulse, then watch the adjust pulses for a while
   task frame;
      saw_i = 1'b0;
      saw_g = 1'b0;
      @(posedge clk) pixel_frame <= 1'b1;
      @(posedge clk) pixel_frame <= 1'b0;
      // A step pulse stands only in the cycle after the frame edge
      repeat (6) begin
         #1;
         saw_i = saw_i | integ_up;
         saw_g = saw_g | gain_up;
         @(posedge clk);
      end
   endtask
   task t_reset;
      rchk(12'h804, 32'h820000b8);
      rchk(12'h808, 32'h0);
      rchk(12'h80c, 32'h80032032);
      rchk(12'h900, 32'h0);
      check("red", {20'h0, red_gain}, 32'h016);
   endtask
   task t_color;
      host.put(12'h80c, 32'h02000000);
      host.put(12'h80c, 32'h02123456);
      rchk(12'h80c, 32'h82123456);
      check("red", {20'h0, red_gain}, 32'h456);
      check("blue", {20'h0, blue_gain}, 32'h123);
      host.put(12'h80c, 32'h00123456);
   endtask
   task t_expo;
      @(posedge clk) integ_auto <= 1'b1;
      host.put(12'h804, 32'h02000123);
      host.put(12'h804, 32'h03000123);
      host.put(12'h804, 32'h03000555);
      rchk(12'h804, 32'h83000123);
      check("active", {31'h0, expo_active}, 32'h1);
      @(posedge clk) gain_auto <= 1'b1;
      host.put(12'h804, 32'h02000123);
      frame;
      check("integ up", {31'h0, saw_i}, 32'h1);
      check("gain up", {31'h0, saw_g}, 32'h0);
      host.put(12'h804, 32'h00000123);
      frame;
      check("off up", {31'h0, saw_i}, 32'h0);
      host.put(12'h804, 32'h01000777);
      rchk(12'h804, 32'h80000123);
   endtask
   task t_auto_shot;
      host.put(12'h804, 32'h02000123);
      avg_intensity <= 12'h2a5;
      host.put(12'h804, 32'h03000123);
      rchk(12'h804, 32'h830002a5);
      host.put(12'h804, 32'h02000123);
      avg_intensity <= 12'h0c0;
      host.put(12'h804, 32'h06000000);
      host.get(12'h804, d);
      check("busy", {31'h0, d[26]}, 32'h1);
      frame;
      rchk(12'h804, 32'h820000c0);
      host.put(12'h804, 32'h42000000);
      rchk(12'h804, 32'hc2000170);
   endtask
   task print_verdict;
      $display("checked %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #100000;
      errors = errors + 1;
      print_verdict;
   end
   initial begin
      rst = 1'b1;
      integ_auto = 1'b0;
      gain_auto = 1'b0;
      pixel_frame = 1'b0;
      integ_setting = 12'h100;
      avg_intensity = 12'h050;
      gain_setting = 12'h200;
      abs_exposure = 12'h001;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset;
      t_color;
      t_expo;
      t_auto_shot;
      print_verdict;
   end
endmodule

// [src/ecf_csr.v]
/*
 * Exposure, edge enhance and colour gain control registers with a simple
 * exposure controller and colour gain selection.
 * The exposure controller nudges integration or gain by one step per
 * frame; it does not model how far a step moves the image level.
 * Assumes a register port with one-cycle strobes and read data one cycle
 * later; integration and gain mode bits come from elsewhere as levels,
 * and one frame pulse per image arrives on pixel_frame.
 */
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "ecf_map.vh"

module ecf_csr #(
   parameter COLOR = 1,
   parameter [15:0] ONESHOT_CYC = `ECF_ONESHOT_CYC
) (
   input wire clk,
   input wire rst,
   input wire [11:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   input wire integ_auto,
   input wire gain_auto,
   input wire [11:0] integ_setting,
   input wire [11:0] gain_setting,
   input wire [11:0] avg_intensity,
   input wire [11:0] abs_exposure,
   input wire [11:0] abs_red,
   input wire [11:0] abs_blue,
   input wire pixel_frame,
   output reg [31:0] rdata,
   output reg expo_active,
   output reg integ_up,
   output reg integ_down,
   output reg gain_up,
   output reg gain_down,
   output reg [11:0] red_gain,
   output reg [11:0] blue_gain,
   output reg [11:0] green_gain
);

   // Exposure control word state
   reg ex_abs;
   reg ex_one;
   reg ex_en;
   reg ex_auto;
   reg [11:0] ex_val;
   // Colour gain control word state
   reg wb_abs;
   reg wb_one;
   reg wb_en;
   reg wb_auto;
   reg [11:0] wb_red;
   reg [11:0] wb_blue;
   reg [15:0] wb_cnt;
   // Exposure target level, and the level reported in the value field
   reg [11:0] target;
   reg [11:0] ex_used;
   // Step decisions for the coming frame, registered before they leave
   reg next_integ_up;
   reg next_integ_down;
   reg next_gain_up;
   reg next_gain_down;
   reg [31:0] next_rdata;

   // Power-up gains follow the sensor type; held as constants so the
   // asynchronous reset branch loads nothing but fixed values
   localparam [11:0] RST_RED = COLOR ? `ECF_RED_COLOR : `ECF_GAIN_MONO;
   localparam [11:0] RST_BLUE = COLOR ? `ECF_BLUE_COLOR : `ECF_GAIN_MONO;

   wire [15:0] oneshot_len = ONESHOT_CYC;
   wire wr_ex = wr && hit(addr, `ECF_OFS_EXPO);
   wire wr_wb = wr && hit(addr, `ECF_OFS_GAIN);
   wire ex_run = ex_en && (integ_auto || gain_auto);
   wire ex_all_auto = ex_auto && integ_auto && gain_auto;
   wire wb_run = wb_en && (wb_auto || wb_one);
   wire [11:0] def_red = COLOR ? `ECF_RED_COLOR : `ECF_GAIN_MONO;
   wire [11:0] def_blue = COLOR ? `ECF_BLUE_COLOR : `ECF_GAIN_MONO;
   wire [11:0] def_green = COLOR ? `ECF_GREEN_COLOR : `ECF_GAIN_MONO;

   // Pack the common feature layout; bit 0 is the MSB
   function [31:0] pack;
      input present;
      input abs_sel;
      input one;
      input en;
      input auto_sel;
      input [11:0] mid;
      input [11:0] val;
      begin
         pack = 32'h0000_0000;
         pack[`ECF_B_PRESENT] = present;
         pack[`ECF_B_ABS] = abs_sel;
         pack[`ECF_B_ONESHOT] = one;
         pack[`ECF_B_ENABLE] = en;
         pack[`ECF_B_AUTO] = auto_sel;
         pack[`ECF_BLUE_HI:`ECF_BLUE_LO] = mid;
         pack[`ECF_VAL_HI:`ECF_VAL_LO] = val;
      end
   endfunction

   // Address match, shared by the write strobes and the read mux
   function hit;
      input [11:0] a;
      input [11:0] ofs;
      begin
         hit = (a == ofs);
      end
   endfunction

   // One gain code toward the mid code per frame; small steps keep the
   // balance from hunting when the scene is already close
   function [11:0] toward_mid;
      input [11:0] g;
      begin
         if (g < `ECF_MID_GAIN)
            toward_mid = g + 12'h001;
         else if (g > `ECF_MID_GAIN)
            toward_mid = g - 12'h001;
         else
            toward_mid = g;
      end
   endfunction

   // Absolute steps against the normal level: each step doubles or
   // halves it; beyond two steps up the 10-bit scale is already full
   function [11:0] abs_target;
      input [11:0] steps;
      begin
         if (steps[11])
            abs_target = `ECF_NORMAL_LEVEL >> (~steps[3:0] + 4'h1);
         else if (steps[3:0] > 4'h2)
            abs_target = `ECF_FULL_SCALE;
         else
            abs_target = `ECF_NORMAL_LEVEL << steps[3:0];
      end
   endfunction

   // Target from absolute steps, the normal level in full auto, or the written field; each step
   // doubles or halves the level, so the normal level is shifted by the step count, up to full scale
   always @* begin
      if (ex_abs) begin
         target = abs_target(abs_exposure);
      end else if (ex_all_auto) begin
         target = `ECF_NORMAL_LEVEL;
      end else begin
         target = ex_val;
      end
   end

   // Value field shows the level actually in use
   always @* begin
      if (ex_all_auto)
         ex_used = avg_intensity;
      else
         ex_used = target;
   end

   // Exposure control word writes
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ex_abs <= 1'b0;
         ex_one <= 1'b0;
         ex_en <= 1'b1;
         ex_auto <= 1'b0;
         ex_val <= `ECF_NORMAL_LEVEL;
      end else begin
         if (wr_ex) begin
            ex_en <= wdata[`ECF_B_ENABLE];
         end
         // Other fields only change while the feature is on
         if (wr_ex && ex_en) begin
            ex_abs <= wdata[`ECF_B_ABS];
            ex_auto <= wdata[`ECF_B_AUTO];
            if (!wdata[`ECF_B_AUTO] && !ex_auto)
               ex_one <= wdata[`ECF_B_ONESHOT];
            if (!ex_auto && !ex_abs && !ex_one)
               ex_val <= wdata[`ECF_VAL_HI:`ECF_VAL_LO];
         end else if (ex_one && pixel_frame) begin
            // Settle for one frame, then back to manual with level kept
            ex_val <= avg_intensity;
            ex_one <= 1'b0;
         end
      end
   end

   // Exposure stepping: integration first, gain once it is maxed or not in auto.
   // Long integration with low gain gives the cleaner image, so on the
   // way down gain is cut before integration is shortened.
   always @* begin
      next_integ_up = 1'b0;
      next_integ_down = 1'b0;
      next_gain_up = 1'b0;
      next_gain_down = 1'b0;
      if (ex_run && pixel_frame) begin
         if (avg_intensity < target) begin
            if (integ_auto && integ_setting != `ECF_SETTING_MAX)
               next_integ_up = 1'b1;
            else if (gain_auto)
               next_gain_up = 1'b1;
         end else if (avg_intensity > target) begin
            if (gain_auto && gain_setting != 12'h000)
               next_gain_down = 1'b1;
            else if (integ_auto)
               next_integ_down = 1'b1;
         end
      end
   end

   // Step pulses leave straight from flip-flops, one per frame at most
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         expo_active <= 1'b0;
         integ_up <= 1'b0;
         integ_down <= 1'b0;
         gain_up <= 1'b0;
         gain_down <= 1'b0;
      end else begin
         expo_active <= ex_run;
         integ_up <= next_integ_up;
         integ_down <= next_integ_down;
         gain_up <= next_gain_up;
         gain_down <= next_gain_down;
      end
   end

   // Colour gain control word and one-shot timer
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wb_abs <= 1'b0;
         wb_one <= 1'b0;
         wb_en <= 1'b0;
         wb_auto <= 1'b0;
         wb_red <= RST_RED;
         wb_blue <= RST_BLUE;
         wb_cnt <= 16'h0000;
      end else begin
         if (wr_wb)
            wb_en <= wdata[`ECF_B_ENABLE];
         if (wr_wb && wb_en) begin
            wb_abs <= wdata[`ECF_B_ABS];
            wb_auto <= wdata[`ECF_B_AUTO];
            if (!wdata[`ECF_B_AUTO] && !wb_auto && wdata[`ECF_B_ONESHOT]) begin
               wb_one <= 1'b1;
               wb_cnt <= oneshot_len;
            end
            if (!wb_auto && !wb_one) begin
               wb_red <= wdata[`ECF_VAL_HI:`ECF_VAL_LO];
               wb_blue <= wdata[`ECF_BLUE_HI:`ECF_BLUE_LO];
            end
         end else begin
            if (wb_one) begin
               if (wb_cnt == 16'h0001)
                  wb_one <= 1'b0;
               wb_cnt <= wb_cnt - 16'h0001;
            end
            // Nudge red and blue toward mid while balancing; a one-shot
            // does the same work, only bounded by its timer
            if (wb_run && !wb_abs && pixel_frame) begin
               wb_red <= toward_mid(wb_red);
               wb_blue <= toward_mid(wb_blue);
            end
         end
      end
   end

   // Per-pixel gains; mid code means no relative change
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         red_gain <= `ECF_MID_GAIN;
         blue_gain <= `ECF_MID_GAIN;
         green_gain <= `ECF_MID_GAIN;
      end else begin
         green_gain <= def_green;
         if (!wb_en) begin
            red_gain <= def_green;
            blue_gain <= def_green;
         end else if (wb_abs) begin
            red_gain <= abs_red;
            blue_gain <= abs_blue;
         end else begin
            red_gain <= wb_red;
            blue_gain <= wb_blue;
         end
      end
   end

   // Read mux; unmapped reads give zero, and so does any cycle without a
   // read strobe, so a stale word never lingers on the port
   always @* begin
      if (!rd) begin
         next_rdata = 32'h0000_0000;
      end else if (hit(addr, `ECF_OFS_EXPO)) begin
         next_rdata = pack(1'b1, ex_abs, ex_one, ex_en, ex_auto, 12'h000,
                           ex_used);
      end else if (hit(addr, `ECF_OFS_EDGE)) begin
         next_rdata = 32'h0000_0000;
      end else if (hit(addr, `ECF_OFS_GAIN)) begin
         next_rdata = pack(1'b1, wb_abs, wb_one, wb_en, wb_auto, wb_blue,
                           wb_red);
      end else if (hit(addr, `ECF_OFS_SENS)) begin
         next_rdata = {8'h00, def_red, def_blue}; // Colour defaults
      end else begin
         next_rdata = 32'h0000_0000;
      end
   end

   // Read data one cycle after the strobe, straight from a register
   always @(posedge clk or posedge rst) begin
      if (rst)
         rdata <= 32'h0000_0000;
      else
         rdata <= next_rdata;
   end

endmodule

// [src/ecf_map.vh]
/*
 * Register offsets, bit positions and reset values for the exposure,
 * edge enhance and colour gain control words.
 * Assumes a word-addressed register port with 12-bit byte offsets.
 */
`ifndef ECF_MAP_VH
`define ECF_MAP_VH

// Register byte offsets
`define ECF_OFS_EXPO 12'h804
`define ECF_OFS_EDGE 12'h808
`define ECF_OFS_GAIN 12'h80c
`define ECF_OFS_SENS 12'h840

// Bit 0 of a word is its most significant bit, so field
// bit n sits at Verilog index 31-n
`define ECF_B_PRESENT 31
`define ECF_B_ABS 30
`define ECF_B_ONESHOT 26
`define ECF_B_ENABLE 25
`define ECF_B_AUTO 24
`define ECF_VAL_HI 11
`define ECF_VAL_LO 0
`define ECF_BLUE_HI 23
`define ECF_BLUE_LO 12

// Exposure figures on a 10-bit scale, and the 12-bit mid gain code
`define ECF_FULL_SCALE 12'h3ff
`define ECF_NORMAL_LEVEL 12'h0b8
`define ECF_MID_GAIN 12'h800

// Default colour gains
`define ECF_RED_COLOR 12'h032
`define ECF_GREEN_COLOR 12'h016
`define ECF_BLUE_COLOR 12'h032
`define ECF_GAIN_MONO 12'h020

// Control limits
`define ECF_SETTING_MAX 12'hfff
`define ECF_ONESHOT_CYC 16'h0400

`endif
